// ---- hw/crd_raster_top.sv ----
// Raster timing, row fetch pacing and character attribute decode with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module crd_raster_top
  import crd_pkg::*;
#(
  parameter int DEPTH = 80  // Characters per row buffer
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        char_clock_in,
  input  wire logic        fetch_ack_in,
  input  wire logic [7:0]  fetch_data_in,
  output logic             fetch_request_out,
  output logic             irq_out,
  output logic             horiz_retrace_out,
  output logic             vert_retrace_out,
  output logic             video_suppress_out,
  output logic             light_enable_out,
  output logic             highlight_out,
  output logic      [1:0]  line_attr_out,
  output logic      [3:0]  line_addr_out,
  output logic      [6:0]  char_code_out
);
  initial
  begin
    if (DEPTH < 1 || DEPTH > 128)
      $error("DEPTH must be 1 to 128");
  end

  // Attribute pattern per line class, packed {la1,la0,vsp,light_enable_out}
  function automatic logic [3:0] crd_attr(input logic [3:0] code, input crd_cls_t cls);
    logic [11:0] t;
    t = 12'h000;
    unique case (code)
      4'h0: t = 12'h284;
      4'h1: t = 12'h2C4;
      4'h2: t = 12'h482;
      4'h3: t = 12'h4C2;
      4'h4: t = 12'h214;
      4'h5: t = 12'h4C4;
      4'h6: t = 12'h484;
      4'h7: t = 12'h412;
      4'h8: t = 12'h212;
      4'h9: t = 12'h444;
      4'hA: t = 12'h414;
      4'hB: t = 12'h000;  // Nothing asserted
      4'hC: t = 12'h222;  // Special group: all lines suppressed
      default: t = 12'h000;  // Illegal codes held quiet
    endcase
    unique case (cls)
      CRD_ABOVE: crd_attr = t[11:8];
      CRD_ON:    crd_attr = t[7:4];
      default:   crd_attr = t[3:0];
    endcase
  endfunction

  // Special control code test, used by fill and display side
  function automatic logic crd_is_spec(input logic [7:0] c);
    crd_is_spec = (c[7:4] == CRD_SPEC_HI) && (c[3:2] == 2'b00);
  endfunction

  // Bus registers
  logic [31:0] fmt0_q;        // Screen format
  logic [31:0] fmt1_q;        // Row format and pacing
  logic        disp_en_q;     // Display running
  logic        int_en_q;      // Interrupt enable
  logic        underrun_q;    // Sticky underrun
  logic        wr_pend_q;     // Write data phase due
  logic [7:0]  wr_addr_q;     // Write address
  // Pin synchronisers {ack, char_clock_in, data}
  logic [9:0]  sync1_q;       // Only feeds sync2
  logic [9:0]  sync2_q;
  logic [9:0]  sync3_q;
  logic        char_clock_in_lvl_q;    // Agreed char clock level
  logic        ack_lvl_q;     // Agreed ack level
  // Raster counters
  logic [6:0]  char_cnt_q;    // Char within line
  logic [3:0]  line_cnt_q;    // Line within row
  logic [6:0]  row_cnt_q;     // Row within frame
  logic [5:0]  frame_cnt_q;   // Frames for blink
  logic        eor_q;         // End of row seen on this line
  // Row buffers and fill control
  logic [7:0]  buf_q [2][DEPTH];
  logic        disp_sel_q;    // Buffer being shown
  logic        fill_sel_q;    // Buffer being filled
  logic [6:0]  fill_cnt_q;    // Chars written
  logic        fill_done_q;   // Buffer full or stopped
  logic        fill_act_q;    // Fetching allowed this row
  crd_fetch_t  fstate_q;
  logic [2:0]  burst_cnt_q;   // Chars in current burst
  logic [5:0]  gap_cnt_q;     // Clocks left in gap

  // Field views
  logic [6:0] chars_m1, hrt_m1, rows_m1, row_last;
  logic [3:0] lines_m1, ul_line;
  logic [1:0] vrt_m1;
  logic [2:0] burst_m1;
  logic [5:0] gap_len;
  logic       lc_mode;
  assign chars_m1 = fmt0_q[CRD_CHARS_LSB +: 7];
  assign hrt_m1   = {2'b00, fmt0_q[CRD_HRT_LSB +: 5]};
  assign lines_m1 = fmt0_q[CRD_LINES_LSB +: 4];
  assign rows_m1  = {1'b0, fmt0_q[CRD_ROWS_LSB +: 6]};
  assign vrt_m1   = fmt0_q[CRD_VRT_LSB +: 2];
  assign ul_line  = fmt1_q[CRD_UL_LSB +: 4];
  assign lc_mode  = fmt1_q[CRD_MODE_BIT];
  assign burst_m1 = fmt1_q[CRD_BURST_LSB +: 3];
  // Gaps above the documented range are held at the top
  assign gap_len  = (fmt1_q[CRD_GAP_LSB +: 6] > CRD_GAP_MAX) ? CRD_GAP_MAX : fmt1_q[CRD_GAP_LSB +: 6];
  assign row_last = rows_m1 + 7'(vrt_m1) + 7'd1;

  // Bus decode
  logic addr_ok, rd_acc, stat_rd, rst_cmd;
  assign addr_ok = hsel && hready && htrans[1];
  assign rd_acc  = addr_ok && !hwrite;
  assign stat_rd = rd_acc && (haddr[7:0] == CRD_STATUS_OFS);
  assign rst_cmd = wr_pend_q && (wr_addr_q == CRD_CMD_OFS) && hwdata[CRD_RSTC_BIT];

  // Char clock tick and ack edge from agreed levels
  logic char_clock_in_tick, ack_edge;
  logic [7:0] fetch_byte;
  assign char_clock_in_tick  = (sync2_q[8] == sync3_q[8]) && sync3_q[8] && !char_clock_in_lvl_q;
  assign ack_edge   = (sync2_q[9] == sync3_q[9]) && sync3_q[9] && !ack_lvl_q;
  assign fetch_byte = sync3_q[7:0];

  // Raster position events
  logic line_end, row_end, in_hrt, in_vrt, row_disp;
  logic [6:0] next_row;
  assign line_end = char_clock_in_tick && (char_cnt_q == chars_m1 + hrt_m1 + 7'd1);
  assign row_end  = line_end && (line_cnt_q == lines_m1);
  assign next_row = (row_cnt_q == row_last) ? 7'd0 : row_cnt_q + 7'd1;
  assign in_hrt   = char_cnt_q > chars_m1;
  assign in_vrt   = row_cnt_q > rows_m1;
  assign row_disp = !in_vrt;

  // Pin synchronisers, three stages
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
      sync3_q <= 10'h000;
    end
    else
    begin
      sync1_q <= {fetch_ack_in, char_clock_in, fetch_data_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Agreed levels change only when stages two and three match
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      char_clock_in_lvl_q <= 1'b0;
      ack_lvl_q  <= 1'b0;
    end
    else
    begin
      if (sync2_q[8] == sync3_q[8])
        char_clock_in_lvl_q <= sync3_q[8];
      if (sync2_q[9] == sync3_q[9])
        ack_lvl_q <= sync3_q[9];
    end
  end

  // AHB-Lite slave: zero wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr[7:0];
      if (rd_acc)
      begin
        // Read data captured in address phase, shown in data phase
        unique case (haddr[7:0])
          CRD_FMT0_OFS:   hrdata <= fmt0_q;
          CRD_FMT1_OFS:   hrdata <= fmt1_q;
          CRD_CTRL_OFS:   hrdata <= {30'h0, int_en_q, disp_en_q};
          CRD_STATUS_OFS: hrdata <= {30'h0, underrun_q, irq_out};
          default:        hrdata <= 32'h0000_0000;  // Unmapped reads zero
        endcase
      end
    end
  end

  // Format and control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fmt0_q    <= CRD_FMT0_RST;
      fmt1_q    <= CRD_FMT1_RST;
      disp_en_q <= 1'b0;
      int_en_q  <= CRD_IEN_RST;  // Host clears it by reset command
    end
    else if (rst_cmd)
    begin
      // Reset command stops fetching and disables interrupts
      disp_en_q <= 1'b0;
      int_en_q  <= 1'b0;
    end
    else if (wr_pend_q)
    begin
      unique case (wr_addr_q)
        CRD_FMT0_OFS: fmt0_q <= hwdata;
        CRD_FMT1_OFS: fmt1_q <= hwdata;
        CRD_CTRL_OFS:
        begin
          disp_en_q <= hwdata[CRD_DISP_BIT];
          int_en_q  <= hwdata[CRD_IEN_BIT];
        end
        default: ;  // Other writes ignored
      endcase
    end
  end

  // Interrupt request: set wins over a clearing read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_out <= 1'b0;
    else if (row_end && int_en_q && (next_row == rows_m1))
      irq_out <= 1'b1;
    else if (stat_rd || rst_cmd)
      irq_out <= 1'b0;
  end

  // Underrun flag: row starts before its buffer is full
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      underrun_q <= 1'b0;
    else if (row_end && disp_en_q && fill_act_q && !fill_done_q)
      underrun_q <= 1'b1;
    else if (stat_rd || rst_cmd)
      underrun_q <= 1'b0;
  end

  // Character, line and row counters on the char clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      char_cnt_q  <= 7'd0;
      line_cnt_q  <= 4'd0;
      row_cnt_q   <= 7'd0;
      frame_cnt_q <= 6'd0;
    end
    else if (char_clock_in_tick)
    begin
      char_cnt_q <= line_end ? 7'd0 : char_cnt_q + 7'd1;
      if (line_end)
        line_cnt_q <= row_end ? 4'd0 : line_cnt_q + 4'd1;
      if (row_end)
        row_cnt_q <= next_row;
      if (row_end && next_row == 7'd0)
        frame_cnt_q <= frame_cnt_q + 6'd1;
    end
  end

  // Fill window: opens at row start for the coming displayed row
  logic fetch_next;
  assign fetch_next = (next_row < rows_m1) || (next_row == row_last);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      disp_sel_q  <= 1'b0;
      fill_sel_q  <= 1'b0;
      fill_act_q  <= 1'b0;
      fill_done_q <= 1'b0;
      fill_cnt_q  <= 7'd0;
    end
    else if (rst_cmd || !disp_en_q)
    begin
      fill_act_q  <= 1'b0;
      fill_done_q <= 1'b0;
    end
    else if (row_end)
    begin
      // Buffers swap when the next row is displayed; no requests until this point
      if (next_row <= rows_m1)
        disp_sel_q <= fill_sel_q;
      fill_sel_q  <= (next_row <= rows_m1) ? !fill_sel_q : fill_sel_q;
      fill_act_q  <= fetch_next;
      fill_done_q <= 1'b0;
      fill_cnt_q  <= 7'd0;
    end
    else if (ack_edge && fill_act_q && !fill_done_q)
    begin
      fill_cnt_q <= fill_cnt_q + 7'd1;
      if (fill_cnt_q == chars_m1)
        fill_done_q <= 1'b1;
      else if (crd_is_spec(fetch_byte) && fetch_byte[0])
        fill_done_q <= 1'b1;  // Stop code ends fetching for the row
    end
  end

  // Row buffer write
  always_ff @(posedge hclk)
  begin
    if (ack_edge && fill_act_q && !fill_done_q && fill_cnt_q < 7'(DEPTH))
      buf_q[fill_sel_q][fill_cnt_q] <= fetch_byte;
  end

  // Burst sequencer: length and gap pacing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fstate_q          <= CRD_F_IDLE;
      burst_cnt_q       <= 3'd0;
      gap_cnt_q         <= 6'd0;
      fetch_request_out <= 1'b0;
    end
    else if (!fill_act_q || fill_done_q || row_end)
    begin
      // Full buffer ends burst at once, count cleared
      fstate_q          <= CRD_F_IDLE;
      burst_cnt_q       <= 3'd0;
      fetch_request_out <= 1'b0;
    end
    else
    begin
      unique case (fstate_q)
        CRD_F_IDLE:
        begin
          fstate_q          <= CRD_F_REQ;
          fetch_request_out <= 1'b1;
        end
        CRD_F_REQ:
        begin
          if (ack_edge)
          begin
            if (burst_cnt_q == burst_m1 || fill_cnt_q == chars_m1)
            begin
              // Burst length reached or last char of the row fetched
              burst_cnt_q       <= 3'd0;
              fetch_request_out <= 1'b0;
              gap_cnt_q         <= gap_len;
              fstate_q          <= (gap_len == 6'd0) ? CRD_F_IDLE : CRD_F_GAP;
            end
            else
              burst_cnt_q <= burst_cnt_q + 3'd1;
          end
        end
        CRD_F_GAP:
        begin
          // Gap counted in char clocks, one clock of slack
          if (char_clock_in_tick)
          begin
            gap_cnt_q <= gap_cnt_q - 6'd1;
            if (gap_cnt_q == 6'd1)
            begin
              fstate_q          <= CRD_F_REQ;
              fetch_request_out <= 1'b1;
            end
          end
        end
        default: fstate_q <= CRD_F_IDLE;
      endcase
    end
  end

  // Display decode
  logic [7:0] cur;
  logic [3:0] apat;
  logic       edge_blank, blink_on;
  crd_cls_t   cls;
  assign cur = (char_cnt_q < 7'(DEPTH)) ? buf_q[disp_sel_q][char_cnt_q] : 8'h00;
  // Line class; an underline past the last line leaves all lines above
  assign cls = (line_cnt_q < ul_line) ? CRD_ABOVE : (line_cnt_q == ul_line) ? CRD_ON : CRD_BELOW;
  assign apat = crd_attr(cur[5:2], cls);
  // Edge lines blank only when underline top bit set
  assign edge_blank = ul_line[3] && (line_cnt_q == 4'd0 || line_cnt_q == lines_m1);
  assign blink_on = cur[1] && frame_cnt_q[CRD_BLINK_BIT];

  // End of row latch, held to end of line
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      eor_q <= 1'b0;
    else if (line_end)
      eor_q <= 1'b0;
    else if (char_clock_in_tick && !in_hrt && row_disp && crd_is_spec(cur))
      eor_q <= 1'b1;
  end

  // Video outputs, refreshed each char clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      horiz_retrace_out  <= 1'b0;
      vert_retrace_out   <= 1'b0;
      video_suppress_out <= 1'b1;
      light_enable_out   <= 1'b0;
      highlight_out      <= 1'b0;
      line_attr_out      <= 2'b00;
      line_addr_out      <= 4'h0;
      char_code_out      <= 7'h00;
    end
    else if (char_clock_in_tick)
    begin
      horiz_retrace_out <= in_hrt;
      vert_retrace_out  <= in_vrt;
      // Mode one outputs line minus one, line zero shows last count
      line_addr_out <= (lc_mode && line_cnt_q == 4'd0) ? lines_m1 :
                       lc_mode ? line_cnt_q - 4'd1 : line_cnt_q;
      char_code_out <= cur[6:0];
      line_attr_out    <= 2'b00;
      light_enable_out <= 1'b0;
      highlight_out    <= 1'b0;
      if (in_hrt || in_vrt || !disp_en_q)
        video_suppress_out <= 1'b1;
      else if (eor_q || crd_is_spec(cur))
        video_suppress_out <= 1'b1;
      else if (cur[7:6] == 2'b10)
      begin
        // Character attribute symbol
        line_attr_out      <= apat[3:2];
        video_suppress_out <= apat[1] || blink_on || edge_blank;
        light_enable_out   <= apat[0];
        highlight_out      <= cur[0];
      end
      else if (cur[7])
        video_suppress_out <= 1'b1;  // Other codes shown blank
      else
        video_suppress_out <= edge_blank;
    end
  end
endmodule
`default_nettype wire

// ---- hw/crd_pkg.sv ----
// Package: register map, field layout, reset values and timing for the raster controller
package crd_pkg;
  // Register byte offsets
  localparam logic [7:0] CRD_FMT0_OFS   = 8'h00;
  localparam logic [7:0] CRD_FMT1_OFS   = 8'h04;
  localparam logic [7:0] CRD_CTRL_OFS   = 8'h08;
  localparam logic [7:0] CRD_STATUS_OFS = 8'h0C;
  localparam logic [7:0] CRD_CMD_OFS    = 8'h10;
  // Format word 0 fields
  localparam int CRD_CHARS_LSB = 0;   // Chars per row minus one, 7 bits
  localparam int CRD_HRT_LSB   = 8;   // Horizontal retrace minus one, 5 bits
  localparam int CRD_LINES_LSB = 16;  // Lines per row minus one, 4 bits
  localparam int CRD_ROWS_LSB  = 20;  // Rows per frame minus one, 6 bits
  localparam int CRD_VRT_LSB   = 26;  // Vertical retrace rows minus one, 2 bits
  // Format word 1 fields
  localparam int CRD_UL_LSB    = 0;   // Underline line, 4 bits
  localparam int CRD_MODE_BIT  = 4;   // Line counter mode
  localparam int CRD_BURST_LSB = 8;   // Burst length minus one, 3 bits
  localparam int CRD_GAP_LSB   = 16;  // Burst gap in char clocks, 6 bits
  // Control, status and command bits
  localparam int CRD_DISP_BIT  = 0;
  localparam int CRD_IEN_BIT   = 1;
  localparam int CRD_IRQ_BIT   = 0;
  localparam int CRD_UNDR_BIT  = 1;
  localparam int CRD_RSTC_BIT  = 0;
  // Reset values
  localparam logic [31:0] CRD_FMT0_RST = 32'h0C97_044F;
  localparam logic [31:0] CRD_FMT1_RST = 32'h0007_0709;
  localparam logic        CRD_IEN_RST  = 1'b1;  // Enable may come up set
  // Limits
  localparam logic [5:0] CRD_GAP_MAX   = 6'h37;
  localparam int         CRD_BLINK_BIT = 4;     // Frame count bit: refresh / 32
  // Special control code
  localparam logic [3:0] CRD_SPEC_HI   = 4'hF;
  localparam logic [3:0] CRD_ATTR_SPEC = 4'hC;
  // Burst sequencer, Gray coded
  typedef enum logic [1:0] {
    CRD_F_IDLE = 2'b00,
    CRD_F_REQ  = 2'b01,
    CRD_F_GAP  = 2'b11
  } crd_fetch_t;
  // Line class against underline line
  typedef enum logic [1:0] {
    CRD_ABOVE = 2'b00,
    CRD_ON    = 2'b01,
    CRD_BELOW = 2'b11
  } crd_cls_t;
endpackage

// ---- tb/crd_raster_monitor.sv ----
// Checker: raster, fetch and interrupt timing seen at the top-level ports
`timescale 1ns/1ps
`default_nettype none
module crd_raster_monitor
  import crd_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        char_clock_in,
  input wire logic        fetch_ack_in,
  input wire logic        fetch_request_out,
  input wire logic        irq_out,
  input wire logic        horiz_retrace_out,
  input wire logic        vert_retrace_out,
  input wire logic        video_suppress_out,
  input wire logic        light_enable_out,
  input wire logic [3:0]  line_addr_out
);
  logic       cc_q;    // Last char clock level
  logic [3:0] age_q;   // Cycles since char clock rose, saturating
  logic       ack_q;   // Last ack level
  logic [3:0] acks_q;  // Acks seen while the request stands
  logic       rd_st;   // Status read taken on the bus
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign rd_st = hsel && hready && htrans[1] && !hwrite && (haddr[7:0] == CRD_STATUS_OFS);
  // Tick age: outputs may only move a few cycles after a char tick
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cc_q  <= 1'b0;
      age_q <= 4'hF;
    end
    else
    begin
      cc_q <= char_clock_in;
      if (char_clock_in && !cc_q)
        age_q <= 4'h0;
      else if (age_q != 4'hF)
        age_q <= age_q + 4'h1;
    end
  end
  // Burst length counter, cleared whenever the request drops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ack_q  <= 1'b0;
      acks_q <= 4'h0;
    end
    else
    begin
      ack_q <= fetch_ack_in;
      if (!fetch_request_out)
        acks_q <= 4'h0;
      else if (fetch_ack_in && !ack_q)
        acks_q <= acks_q + 4'h1;
    end
  end
  property p_retrace_blank;
    (horiz_retrace_out || vert_retrace_out) |-> video_suppress_out;
  endproperty
  a_retrace_blank: assert property (p_retrace_blank) else $error("video shown in retrace");
  property p_retrace_dark;
    (horiz_retrace_out || vert_retrace_out) |-> !light_enable_out;
  endproperty
  a_retrace_dark: assert property (p_retrace_dark) else $error("light enable in retrace");
  property p_htick;
    $changed(horiz_retrace_out) |-> age_q inside {[4'h1:4'h7]};
  endproperty
  a_htick: assert property (p_htick) else $error("horizontal retrace off tick");
  property p_vtick;
    $changed(vert_retrace_out) |-> age_q inside {[4'h1:4'h7]};
  endproperty
  a_vtick: assert property (p_vtick) else $error("vertical retrace off tick");
  property p_line_tick;
    $changed(line_addr_out) |-> age_q inside {[4'h1:4'h7]};
  endproperty
  a_line_tick: assert property (p_line_tick) else $error("line address off tick");
  property p_burst_max;
    acks_q <= 4'h8;
  endproperty
  a_burst_max: assert property (p_burst_max) else $error("burst longer than eight");
  property p_req_tick;
    $rose(fetch_request_out) |-> age_q inside {[4'h1:4'h7]};
  endproperty
  a_req_tick: assert property (p_req_tick) else $error("request off tick");
  property p_irq_clear;
    rd_st |-> ##[1:2] !irq_out;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq kept after status read");
  property p_irq_row;
    $rose(irq_out) |-> !vert_retrace_out;
  endproperty
  a_irq_row: assert property (p_irq_row) else $error("irq raised in retrace");
  c_irq: cover property ($rose(irq_out));
  c_burst: cover property ($fell(fetch_request_out));
  c_under: cover property (light_enable_out && !horiz_retrace_out);
endmodule
bind crd_raster_top crd_raster_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .char_clock_in, .fetch_ack_in, .fetch_request_out, .irq_out, .horiz_retrace_out, .vert_retrace_out,
  .video_suppress_out, .light_enable_out, .line_addr_out);
`default_nettype wire

// ---- tb/crd_dma_partner.sv ----
// Partner: DMA acknowledge pulses, row bytes and the free-running char clock
`timescale 1ns/1ps
`default_nettype none
module crd_dma_partner
(
  input  wire logic       hclk,
  input  wire logic       fetch_request_out,  // Design wants bytes
  input  wire logic       stall,              // Withhold every ack
  input  wire logic [1:0] lag,                // Extra wait before an ack
  input  wire logic [7:0] fill,               // Byte handed over
  output logic            fetch_ack_in,
  output logic      [7:0] fetch_data_in,
  output logic            char_clock_in
);
  // Char clock, phase unrelated to hclk, slow enough for 16 hclk per char
  initial
  begin
    char_clock_in = 1'b0;
    #3.3;
    forever #40 char_clock_in = ~char_clock_in;
  end
  // One byte per pulse: data first, ack high 4 cycles, low at least 3
  initial
  begin
    fetch_ack_in  = 1'b0;
    fetch_data_in = 8'h5A;
    forever
    begin
      @(posedge hclk);
      if (fetch_request_out === 1'b1 && !stall)
      begin
        repeat (lag) @(posedge hclk);
        fetch_data_in <= fill;
        @(posedge hclk);
        fetch_ack_in <= 1'b1;
        repeat (4) @(posedge hclk);
        fetch_ack_in  <= 1'b0;
        fetch_data_in <= ~fetch_data_in;  // Released bus: no stale byte
        repeat (3) @(posedge hclk);
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/crd_raster_top_bench.sv ----
// Self-checking bench: registers, raster video patterns, interrupt and underrun
`timescale 1ns/1ps
`default_nettype none
module crd_raster_top_bench
  import crd_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0, chk_en = 1'b0, stall = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, exp_q[$], msk_q[$];
  logic [1:0]  htrans = 2'h0, lag = 2'h0, line_attr_out;
  logic [7:0]  fill = 8'h41, fetch_data_in;
  logic [2:0]  vm = 3'h0, lm = 3'h0;  // Per-line suppress and light masks
  logic        hl = 1'b0, hreadyout, char_clock_in, fetch_ack_in, fetch_request_out, irq_out;
  logic        horiz_retrace_out, vert_retrace_out, video_suppress_out, light_enable_out, highlight_out;
  logic [3:0]  line_addr_out;
  logic [6:0]  char_code_out;
  integer      seed = 32'he60f;
  int          errors = 0, tests_run = 0, cycles = 0, ln;
  // Phases: byte kind, underline line and the expected masks; no illegal codes
  localparam logic [7:0] PB [5] = '{8'hA1, 8'hA0, 8'h41, 8'h41, 8'hF0};
  localparam logic [3:0] UL [5] = '{4'h1, 4'h5, 4'h9, 4'h1, 4'h1};
  localparam logic [2:0] VM [5] = '{3'h5, 3'h7, 3'h5, 3'h0, 3'h7};
  localparam logic [2:0] LM [5] = '{3'h2, 3'h0, 3'h0, 3'h0, 3'h0};
  crd_raster_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .char_clock_in, .fetch_ack_in, .fetch_data_in,
    .fetch_request_out, .irq_out, .horiz_retrace_out, .vert_retrace_out, .video_suppress_out,
    .light_enable_out, .highlight_out, .line_attr_out, .line_addr_out, .char_code_out);
  crd_dma_partner far_end (.hclk, .fetch_request_out, .stall, .lag, .fill, .fetch_ack_in,
    .fetch_data_in, .char_clock_in);
  always #2.5 hclk = ~hclk;
  // Random ack lag; timeout cuts a hang
  always @(posedge hclk)
  begin
    lag <= 2'($random(seed));
    cycles++;
    if (cycles == 60000)
    begin
      errors++;
      end_of_test();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Single AHB transfer; a read notes its expectation first
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    if (!w)
    begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  // Read data watcher takes the oldest note
  always @(posedge hclk)
    if (rd_ph && hreadyout)
      check("hrdata", hrdata & msk_q.pop_front(), exp_q.pop_front());
  // Wait for the frame interrupt, then acknowledge it by a status read
  task automatic frame();
    do @(posedge hclk); while (irq_out !== 1'b1);
    bus(1'b0, CRD_STATUS_OFS, 32'h1, 32'h1);
    repeat (3) @(posedge hclk);
  endtask
  // Video watcher, mid character; mode 1 with three lines maps address 2 to line 0
  always @(negedge char_clock_in)
    if (chk_en && !horiz_retrace_out && !vert_retrace_out)
    begin
      ln = (line_addr_out == 4'h2) ? 0 : int'(line_addr_out) + 1;
      check("suppress", 32'(video_suppress_out), 32'(vm[ln]));
      check("light", 32'(light_enable_out), 32'(lm[ln]));
      check("highlight", 32'(highlight_out), 32'(hl));
      check("lattr", 32'(line_attr_out), 32'h0);
      if (!fill[7])
        check("code", 32'(char_code_out), 32'(fill[6:0]));
    end
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, CRD_FMT0_OFS, CRD_FMT0_RST, '1);
    bus(1'b0, CRD_FMT1_OFS, CRD_FMT1_RST, '1);
    bus(1'b0, CRD_CTRL_OFS, 32'h2, '1);
    bus(1'b0, 8'h14, 32'h0, '1);
    bus(1'b1, CRD_CMD_OFS, 32'h1, '0);
    bus(1'b0, CRD_CTRL_OFS, 32'h0, '1);
    bus(1'b1, CRD_FMT0_OFS, 32'h0012_0103, '0);
    bus(1'b0, CRD_FMT0_OFS, 32'h0012_0103, '1);
    for (int p = 0; p < 5; p++)
    begin
      bus(1'b1, CRD_FMT1_OFS, 32'h0001_0110 | 32'(UL[p]), '0);
      bus(1'b1, CRD_CTRL_OFS, 32'h3, '0);
      fill <= PB[p];
      vm <= VM[p];
      lm <= LM[p];
      hl <= (p == 0);
      frame();
      frame();
      chk_en <= 1'b1;
      frame();
      chk_en <= 1'b0;
    end
    stall <= 1'b1;
    frame();
    do @(posedge hclk); while (irq_out !== 1'b1);
    bus(1'b0, CRD_STATUS_OFS, 32'h3, 32'h3);
    stall <= 1'b0;
    do @(posedge hclk); while (irq_out !== 1'b1);
    bus(1'b1, CRD_CMD_OFS, 32'h1, '0);
    repeat (4) @(posedge hclk);
    check("irq", 32'(irq_out), 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
